// ### logic/gpe_level_encoder.sv
// GPIO output levels, pin routing and pin-0 PWM level encoder
`timescale 1ns/1ns
`default_nettype none

module gpe_level_encoder import gpe_pkg::*; (
	input  wire logic         clk_sys,     // System clock, 50 MHz
	input  wire logic         rst,         // Synchronous reset, active high
	input  wire gpe_reg_req_s reg_req,     // Register write/read request
	output logic [15:0]       reg_rdata,   // Read data, valid the cycle after rd
	input  wire gpe_alt_s     alt_src,     // Alternate-function pin sources
	input  wire logic [4:0]   gpio_in,     // Pin input levels (asynchronous)
	output logic [4:0]        gpio_out,    // Pin output levels
	output logic [4:0]        gpio_oe      // Pin output enables, high drives
);

	gpe_top_s   r;
	gpe_top_s   next_r;
	logic       pwm_out;
	logic [4:0] pin_dir;
	logic [4:0] pin_fmt;
	logic [4:0] pin_src;
	logic [4:0] alt_vec;
	logic [4:0] pin_level;

	// ==========================================================
	// Configuration fields and logical pin levels
	assign pin_dir = r.cfg[DIR_LSB +: PIN_COUNT];
	assign pin_fmt = r.cfg[FMT_LSB +: PIN_COUNT];
	assign pin_src = r.cfg[SRC_LSB +: PIN_COUNT] | SRC_FIXED_GPIO;
	assign alt_vec = {
		alt_src.overcurrent_b_output,
		alt_src.overcurrent_a_output,
		alt_src.fault_output,
		1'b0,
		alt_src.missing_host_detect
	};

	// Source bit picks data register or alternate function per pin
	always_comb begin
		pin_level = '0;
		for (int k = 0; k < PIN_COUNT; k++) begin
			pin_level[k] = pin_src[k] ? r.levels[k] : alt_vec[k];
		end
	end

	// ==========================================================
	// Pin-0 waveform generator
	// The generator runs whatever the format bit says, so switching to PWM
	// starts on a running time base instead of waiting for a restart.
	gpe_pwm_gen u_pwm (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.level     (pin_level[0]),
		.low_wave  (r.low_wave),
		.high_wave (r.high_wave),
		.pwm_out   (pwm_out)
	);

	// ==========================================================
	// Next state
	always_comb begin
		next_r       = r;
		next_r.sync1 = gpio_in;
		next_r.sync2 = r.sync1;

		if (reg_req.wr) begin
			case (reg_req.addr)
				ADDR_LEVELS: begin
					// Upper bits are kept and read back, but only bits 4:0 reach the pins
					next_r.levels = reg_req.wdata;
				end
				ADDR_LOW_WAVE: begin
					next_r.low_wave = gpe_wave_s'(reg_req.wdata);
				end
				ADDR_HIGH_WAVE: begin
					next_r.high_wave = gpe_wave_s'(reg_req.wdata & HIGH_WAVE_MASK);
				end
				ADDR_CFG: begin
					next_r.cfg = reg_req.wdata & CFG_RW_MASK;
				end
				default: begin
				end
			endcase
		end

		if (reg_req.rd) begin
			case (reg_req.addr)
				ADDR_LEVELS: begin
					next_r.rdata = r.levels;
				end
				ADDR_LOW_WAVE: begin
					next_r.rdata = r.low_wave;
				end
				ADDR_HIGH_WAVE: begin
					next_r.rdata = r.high_wave;
				end
				ADDR_CFG: begin
					next_r.rdata = r.cfg;
				end
				ADDR_PIN_STATE: begin
					next_r.rdata = {{PIN_ST_PAD{1'b0}}, r.sync2};
				end
				default: begin
					next_r.rdata = '0;
				end
			endcase
		end

		// Pins not driven are parked low so the output never floats internally
		for (int k = 0; k < PIN_COUNT; k++) begin
			next_r.pin_oe[k]  = pin_dir[k];
			next_r.pin_out[k] = pin_dir[k] & pin_level[k];
		end
		if (pin_fmt[0]) begin
			next_r.pin_out[0] = pin_dir[0] & pwm_out;
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			r           <= '0;
			r.levels    <= LEVELS_RESET;
			r.low_wave  <= gpe_wave_s'(LOW_WAVE_RESET);
			r.high_wave <= gpe_wave_s'(HIGH_WAVE_RESET);
			r.cfg       <= CFG_RESET;
		end else begin
			r <= next_r;
		end
	end

	assign reg_rdata = r.rdata;
	assign gpio_out  = r.pin_out;
	assign gpio_oe   = r.pin_oe;

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence s_levels_write;
		reg_req.wr && reg_req.addr == ADDR_LEVELS;
	endsequence

	sequence s_levels_read;
		reg_req.rd && reg_req.addr == ADDR_LEVELS;
	endsequence

	chk_pin1_level: assert property (pin_dir[1] |=>
		gpio_oe[1] && gpio_out[1] == $past(r.levels[1]))
		else $error("pin 1 level not from data bit");
	chk_input_float: assert property (!pin_dir[2] |=> !gpio_oe[2])
		else $error("input pin is driven");
	chk_alt_route: assert property (pin_dir[3] && !pin_src[3] |=>
		gpio_out[3] == $past(alt_src.overcurrent_a_output))
		else $error("alternate source not routed");
	chk_spare_store: assert property (s_levels_write ##1 !reg_req.wr ##1 s_levels_read |=>
		reg_rdata == $past(reg_req.wdata, 3))
		else $error("spare bits not stored");
	chk_pin0_static: assert property (pin_dir[0] && !pin_fmt[0] && pin_src[0] |=>
		gpio_out[0] == $past(r.levels[0]))
		else $error("static pin 0 level wrong");
	chk_host_route: assert property (pin_dir[0] && !pin_fmt[0] && !pin_src[0] |=>
		gpio_out[0] == $past(alt_src.missing_host_detect))
		else $error("host detect not routed");
	chk_pwm_route: assert property (pin_dir[0] && pin_fmt[0] |=>
		gpio_out[0] == $past(pwm_out))
		else $error("pwm not routed to pin 0");

endmodule // gpe_level_encoder

`default_nettype wire

// ### logic/gpe_pkg.sv
// Package for the GPIO output level and pin-0 PWM level encoder
package gpe_pkg;

	// ==========================================================
	// Register map
	localparam logic [7:0]  ADDR_PIN_STATE  = 8'h4C;
	localparam logic [7:0]  ADDR_CFG        = 8'h4D;
	localparam logic [7:0]  ADDR_LEVELS     = 8'h4E;
	localparam logic [7:0]  ADDR_LOW_WAVE   = 8'h4F;
	localparam logic [7:0]  ADDR_HIGH_WAVE  = 8'h50;

	localparam logic [15:0] LEVELS_RESET    = 16'h0000;
	localparam logic [15:0] LOW_WAVE_RESET  = 16'h007F;
	localparam logic [15:0] HIGH_WAVE_RESET = 16'h3F80;
	localparam logic [15:0] CFG_RESET       = 16'h0000;
	// Bit 15 and bit 1 of the configuration register are reserved
	localparam logic [15:0] CFG_RW_MASK     = 16'h7FFD;
	// Time-base bits of the high-level waveform register are reserved
	localparam logic [15:0] HIGH_WAVE_MASK  = 16'h3FFF;

	// ==========================================================
	// Field layout
	localparam int          PIN_COUNT       = 5;
	localparam int          FMT_LSB         = 10;
	localparam int          DIR_LSB         = 5;
	localparam int          SRC_LSB         = 0;
	localparam int          PIN_ST_PAD      = 16 - PIN_COUNT;
	// Pin 1 has no alternate function and always takes general-purpose data
	localparam logic [4:0]  SRC_FIXED_GPIO  = 5'h02;

	// ==========================================================
	// Time base, in master-clock periods
	localparam logic [10:0] TICK_CYC_00     = 11'h010;
	localparam logic [10:0] TICK_CYC_01     = 11'h040;
	localparam logic [10:0] TICK_CYC_10     = 11'h100;
	localparam logic [10:0] TICK_CYC_11     = 11'h400;
	localparam logic [6:0]  COUNT_ZERO      = 7'h00;
	localparam logic [6:0]  COUNT_ONE       = 7'h01;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {P_STAT, P_HIGH, P_LOW} gpe_phase_e;

	typedef struct packed {
		logic [1:0] tb;
		logic [6:0] hc;
		logic [6:0] lc;
	} gpe_wave_s;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [15:0] wdata;
	} gpe_reg_req_s;

	typedef struct packed {
		logic               overcurrent_b_output;
		logic               overcurrent_a_output;
		logic               fault_output;
		logic               missing_host_detect;
	} gpe_alt_s;

	typedef struct packed {
		gpe_phase_e phase;
		logic [6:0] cnt;
		logic [6:0] hc_l;
		logic [6:0] lc_l;
		logic [1:0] tb_l;
		logic [9:0] pre;
		logic       out;
	} gpe_pwm_s;

	typedef struct packed {
		logic [15:0] levels;
		gpe_wave_s   low_wave;
		gpe_wave_s   high_wave;
		logic [15:0] cfg;
		logic [4:0]  sync1;
		logic [4:0]  sync2;
		logic [15:0] rdata;
		logic [4:0]  pin_out;
		logic [4:0]  pin_oe;
	} gpe_top_s;

	// ==========================================================
	// Master-clock periods per tick for a time-base code
	function automatic logic [10:0] tick_cycles(input logic [1:0] tb);
		logic [10:0] c;
		c = TICK_CYC_00;
		unique case (tb)
			2'h0: c = TICK_CYC_00;
			2'h1: c = TICK_CYC_01;
			2'h2: c = TICK_CYC_10;
			2'h3: c = TICK_CYC_11;
		endcase
		return c;
	endfunction

endpackage

// ### logic/gpe_pwm_gen.sv
// Pin-0 PWM level generator with time-base prescaler
`timescale 1ns/1ns
`default_nettype none

module gpe_pwm_gen import gpe_pkg::*; (
	input  wire logic      clk_sys,    // System clock
	input  wire logic      rst,        // Synchronous reset
	input  wire logic      level,      // Logical level to encode
	input  wire gpe_wave_s low_wave,   // Waveform for a logical low
	input  wire gpe_wave_s high_wave,  // Waveform for a logical high
	output logic           pwm_out     // Encoded waveform
);

	gpe_pwm_s   r;
	gpe_pwm_s   next_r;
	logic       tick;
	logic [6:0] sel_hc;
	logic [6:0] sel_lc;

	// ==========================================================
	// Tick and waveform selection
	// Time base always comes from the low-level register; compare with >= so a
	// shrinking time base cannot leave the prescaler beyond its wrap point
	assign tick   = ({1'b0, r.pre} >= (tick_cycles(r.tb_l) - 11'h001));
	assign sel_hc = level ? high_wave.hc : low_wave.hc;
	assign sel_lc = level ? high_wave.lc : low_wave.lc;

	// ==========================================================
	// Phase sequencer
	always_comb begin
		next_r     = r;
		next_r.pre = tick ? 10'h000 : (r.pre + 10'h001);
		if (tick) begin
			unique case (r.phase)
				P_HIGH: begin
					if (r.cnt == COUNT_ONE) begin
						next_r.phase = P_LOW;
						next_r.cnt   = r.lc_l;
						next_r.out   = 1'b0;
					end else begin
						next_r.cnt = r.cnt - COUNT_ONE;
					end
				end
				P_LOW, P_STAT: begin
					// New settings are taken only at a period boundary
					if (r.phase == P_STAT || r.cnt == COUNT_ONE) begin
						next_r.hc_l = sel_hc;
						next_r.lc_l = sel_lc;
						next_r.tb_l = low_wave.tb;
						next_r.cnt  = sel_hc;
						if (sel_hc == COUNT_ZERO) begin
							next_r.phase = P_STAT;
							next_r.out   = 1'b0;
						end else if (sel_lc == COUNT_ZERO) begin
							next_r.phase = P_STAT;
							next_r.out   = 1'b1;
						end else begin
							next_r.phase = P_HIGH;
							next_r.out   = 1'b1;
						end
					end else begin
						next_r.cnt = r.cnt - COUNT_ONE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign pwm_out = r.out;

	// ==========================================================
	// Checks
	logic [16:0] hi_run;
	logic [16:0] lo_run;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			hi_run <= 17'h00000;
			lo_run <= 17'h00000;
		end else begin
			hi_run <= (r.phase == P_HIGH) ? (hi_run + 17'h00001) : 17'h00000;
			lo_run <= (r.phase == P_LOW) ? (lo_run + 17'h00001) : 17'h00000;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence s_leave_high;
		$past(r.phase) == P_HIGH ##0 r.phase == P_LOW;
	endsequence

	sequence s_leave_low;
		$past(r.phase) == P_LOW ##0 r.phase != P_LOW;
	endsequence

	// Ticks at which the sequencer takes new settings
	sequence s_period_end;
		tick && (r.phase == P_STAT || (r.phase == P_LOW && r.cnt == COUNT_ONE));
	endsequence

	sequence s_both_zero;
		sel_hc == COUNT_ZERO && sel_lc == COUNT_ZERO;
	endsequence

	chk_high_length: assert property (s_leave_high |->
		hi_run == 17'(r.hc_l) * 17'(tick_cycles(r.tb_l)))
		else $error("high phase length wrong");
	chk_low_length: assert property (s_leave_low |->
		lo_run == 17'($past(r.lc_l)) * 17'(tick_cycles($past(r.tb_l))))
		else $error("low phase length wrong");
	chk_zero_high: assert property (r.phase == P_STAT && r.hc_l == COUNT_ZERO |-> !pwm_out)
		else $error("zero high count not static low");
	chk_zero_low: assert property (r.phase == P_STAT && r.hc_l != COUNT_ZERO |->
		pwm_out && r.lc_l == COUNT_ZERO)
		else $error("zero low count not static high");
	chk_tick_spacing: assert property (tick |->
		{1'b0, r.pre} == tick_cycles(r.tb_l) - 11'h001)
		else $error("tick spacing wrong");
	chk_both_zero: assert property (s_period_end ##0 s_both_zero |=>
		r.phase == P_STAT && !pwm_out)
		else $error("zero counts not static low");

endmodule // gpe_pwm_gen

`default_nettype wire

// ### verification/gpe_level_encoder_tb_top.sv
// Self-checking testbench for the GPIO level and pin-0 PWM encoder
`timescale 1ns/1ns
`default_nettype none

module gpe_level_encoder_tb_top import gpe_pkg::*;;
	logic         clk_sys = 1'b0;
	logic         rst = 1'b1;
	gpe_reg_req_s reg_req = '0;
	gpe_alt_s     alt_src = '0;
	logic [4:0]   gpio_in = 5'h00;
	logic [4:0]   gpio_out, gpio_oe;
	logic [15:0]  reg_rdata, v;
	logic [31:0]  high_len, low_len, edge_cnt, e0, cur_p, tk;
	logic [6:0]   hc, lc;
	logic [13:0]  st [3];
	int           failures = 0, checked = 0, cycles = 0, seed = 49;

	gpe_level_encoder gpe_level_encoder_i (.clk_sys(clk_sys), .rst(rst), .reg_req(reg_req),
		.reg_rdata(reg_rdata), .alt_src(alt_src), .gpio_in(gpio_in), .gpio_out(gpio_out),
		.gpio_oe(gpio_oe));
	gpe_pin_decoder_model gpe_pin_decoder_model_i (.clk_sys(clk_sys), .rst(rst),
		.pin_out(gpio_out[0]), .pin_oe(gpio_oe[0]), .high_len(high_len), .low_len(low_len),
		.edge_cnt(edge_cnt));

	// ==========================================================
	// Clock, watchdog and shared tasks
	initial forever #10 clk_sys = ~clk_sys;

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 90000) begin
			failures++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		$display("checks %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
		#2;
	endtask

	// Request is dropped one cycle before the next may start
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		step(1);
		reg_req = '0;
		step(1);
	endtask

	task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
		reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		step(1);
		reg_req = '0;
		step(1);
		check(reg_rdata, exp);
	endtask

	function automatic logic [31:0] tick_of(input logic [1:0] t);
		return 32'h10 << (2 * t);
	endfunction

	// A new waveform waits for the old period to end, then two new periods are measured
	task automatic pwm(input logic [15:0] d, input logic [7:0] a, input logic [31:0] np);
		wr(a, d);
		step(cur_p + 2 * np + 1100);
		cur_p = np;
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		st = '{14'h0005, 14'h0180, 14'h0000};
		step(12);
		rst = 1'b0;
		rchk(8'h4E, 16'h0000);
		rchk(8'h4F, 16'h007F);
		rchk(8'h50, 16'h3F80);
		wr(8'h60, 16'hFFFF);
		rchk(8'h60, 16'h0000);
		wr(ADDR_CFG, 16'hFFFF);
		rchk(ADDR_CFG, 16'h7FFD);
		wr(8'h4F, 16'h0081);
		wr(ADDR_CFG, 16'h03FF);
		for (int i = 0; i < 8; i++) begin
			v = (i == 0) ? 16'hFFE0 : (i == 1) ? 16'h001F : 16'($random(seed));
			alt_src = 4'($random(seed));
			gpio_in = 5'($random(seed));
			wr(8'h4E, v);
			rchk(8'h4E, v);
			check(gpio_out, v[4:0]);
			check(gpio_oe, 5'h1F);
			rchk(ADDR_PIN_STATE, {11'h000, gpio_in});
		end
		wr(ADDR_CFG, 16'h03E2);
		for (int i = 0; i < 4; i++) begin
			v = 16'($random(seed));
			alt_src = 4'($random(seed));
			wr(8'h4E, v);
			check(gpio_out, {alt_src.overcurrent_b_output, alt_src.overcurrent_a_output,
				alt_src.fault_output, v[1], alt_src.missing_host_detect});
		end
		wr(ADDR_CFG, 16'h001F);
		wr(8'h4E, 16'h001F);
		check({gpio_oe, gpio_out}, 10'h000);
		alt_src = '0;
		wr(8'h4E, 16'h0000);
		cur_p = 32'h20;
		wr(ADDR_CFG, 16'h0421);
		for (int t = 0; t < 5; t++) begin
			hc = (t == 4) ? 7'h7F : 7'h1 + 7'($unsigned($random(seed)) % 3);
			lc = (t == 4) ? 7'h7F : 7'h1 + 7'($unsigned($random(seed)) % 3);
			tk = tick_of(t[1:0]);
			pwm({t[1:0], hc, lc}, 8'h4F, (hc + lc) * tk);
			check(high_len, hc * tk);
			check(low_len, lc * tk);
			check(high_len + low_len, (hc + lc) * tk);
		end
		for (int s = 0; s < 3; s++) begin
			pwm({2'b00, st[s]}, 8'h4F, 32'h0);
			e0 = edge_cnt;
			step(200);
			check(edge_cnt, e0);
			check(gpio_out[0], s == 1);
		end
		wr(8'h4E, 16'h0001);
		step(1100);
		check(gpio_out[0], 1'b1);
		pwm(16'hC103, 8'h50, 32'h50);
		check(high_len, 32'h20);
		check(low_len, 32'h30);
		rchk(8'h50, 16'h0103);
		wr(ADDR_CFG, 16'h0420);
		alt_src.missing_host_detect = 1'b1;
		wr(8'h4E, 16'h0000);
		step(1300);
		// Any window of one period holds exactly two edges; a static pin holds none
		e0 = edge_cnt;
		step(80);
		check(edge_cnt - e0, 32'h2);
		check(high_len, 32'h20);
		check(low_len, 32'h30);
		tally_and_finish();
	end
endmodule // gpe_level_encoder_tb_top

`default_nettype wire

// ### verification/gpe_pin_decoder_model.sv
// Far-side decoder that measures the phases seen on GPIO pin 0
`timescale 1ns/1ns
`default_nettype none

module gpe_pin_decoder_model (
	input  wire logic        clk_sys,   // System clock
	input  wire logic        rst,       // Synchronous reset
	input  wire logic        pin_out,   // Level driven by the device
	input  wire logic        pin_oe,    // Device drives the pin
	output logic      [31:0] high_len,  // Cycles of the last high phase
	output logic      [31:0] low_len,   // Cycles of the last low phase
	output logic      [31:0] edge_cnt   // Level changes seen so far
);
	logic        wire_lvl;
	logic        last;
	logic [31:0] run;

	// Board pull-down holds the line low when the device lets go
	assign wire_lvl = pin_oe & pin_out;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			last     <= 1'b0;
			run      <= 32'h1;
			high_len <= 32'h0;
			low_len  <= 32'h0;
			edge_cnt <= 32'h0;
		end else if (wire_lvl != last) begin
			if (last)
				high_len <= run;
			else
				low_len <= run;
			run      <= 32'h1;
			last     <= wire_lvl;
			edge_cnt <= edge_cnt + 32'h1;
		end else begin
			run <= run + 32'h1;
		end
	end
endmodule // gpe_pin_decoder_model

`default_nettype wire
